/* File: inc/itr_pkg.sv */
/*
 * shared constants, types and rate tables of the input track router.
 * assumes a 250 MHz system clock and 24-bit signed converter words.
 */
`default_nettype none
package itr_pkg;
	// timing
	localparam int unsigned CLK_HZ    = 250_000_000;
	localparam int unsigned BLINK_MS  = 250;
	localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
	localparam int unsigned BLINK_W   = 27;
	// sample widths
	localparam int unsigned SMP_W     = 24;
	localparam int unsigned OUT16_W   = 16;
	localparam int unsigned DROP_BITS = 8;
	localparam int unsigned DITH_W    = 8;
	localparam logic [23:0] PEAK_LEVEL = 24'h5A_9E45; // about -3 dBFS
	localparam logic [23:0] POS_FS     = 24'h7F_FFFF;
	localparam logic [23:0] NEG_FS     = 24'h80_0000;
	localparam logic [15:0] LFSR_SEED  = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS  = 16'hB400;
	// register byte addresses
	localparam logic [7:0] ADR_CTRL  = 8'h00;
	localparam logic [7:0] ADR_CMD   = 8'h04;
	localparam logic [7:0] ADR_ROUTE = 8'h08;
	localparam logic [7:0] ADR_STAT  = 8'h0C;
	localparam logic [7:0] ADR_LABEL = 8'h10;
	// control fields
	localparam int unsigned CTL_MUTE_LSB = 0;
	localparam int unsigned CTL_W16_BIT  = 2;
	localparam int unsigned CTL_DITH_BIT = 3;
	localparam int unsigned CTL_MULT_BIT = 4;
	localparam int unsigned CTL_EXT_BIT  = 5;
	localparam int unsigned CTL_RATE_LSB = 8;
	// command bits
	localparam int unsigned CMD_PRESET = 0;
	localparam int unsigned CMD_EDIT   = 1;
	localparam int unsigned CMD_CURSOR = 2;
	localparam int unsigned CMD_ASSIGN = 3;
	localparam int unsigned CMD_CLEAR  = 4;
	localparam int unsigned CMD_COMMIT = 5;
	// reset values; matrix bit index is input*2+track
	localparam logic [3:0] ROUTE_RST0 = 4'h9;
	localparam logic [3:0] ROUTE_RST1 = 4'h5;
	localparam logic [3:0] ROUTE_RST2 = 4'hA;
	localparam logic [3:0] ROUTE_RST3 = 4'hF;
	localparam logic       DITH_RST   = 1'b1;

	typedef enum logic [0:0] {
		st_main = 1'b0,
		st_edit = 1'b1
	} itr_ui_type;

	typedef enum logic [3:0] {
		rate_32k                           = 4'h0,
		rate_44k1                          = 4'h1,
		rate_47k952                        = 4'h2,
		pulled_down_rate_nominal_label     = 4'h3,
		rate_48k                           = 4'h4,
		rate_48k048                        = 4'h5,
		pulled_up_rate_nominal_label       = 4'h6,
		rate_88k2                          = 4'h7,
		rate_96k                           = 4'h8,
		rate_96k096                        = 4'h9,
		pulled_up_double_rate_nominal_label = 4'hA,
		rate_176k4                         = 4'hB,
		rate_192k                          = 4'hC
	} itr_rate_type;
	localparam itr_rate_type RATE_RST = rate_48k;
	localparam int unsigned  RATE_CNT = 13;

	// true generated rate in Hz
	function automatic logic [17:0] rate_hz(input itr_rate_type r);
		case (r)
			rate_32k:                       rate_hz = 18'h0_7D00;
			rate_44k1:                      rate_hz = 18'h0_AC44;
			rate_47k952, pulled_down_rate_nominal_label:
			                                rate_hz = 18'h0_BB50;
			rate_48k:                       rate_hz = 18'h0_BB80;
			rate_48k048, pulled_up_rate_nominal_label:
			                                rate_hz = 18'h0_BBB0;
			rate_88k2:                      rate_hz = 18'h1_5888;
			rate_96k:                       rate_hz = 18'h1_7700;
			rate_96k096, pulled_up_double_rate_nominal_label:
			                                rate_hz = 18'h1_7760;
			rate_176k4:                     rate_hz = 18'h2_B110;
			rate_192k:                      rate_hz = 18'h2_EE00;
			default:                        rate_hz = 18'h0_BB80;
		endcase
	endfunction

	// rate written into the file header
	function automatic logic [17:0] rate_label(input itr_rate_type r);
		case (r)
			pulled_down_rate_nominal_label: rate_label = 18'h0_BB80;
			pulled_up_rate_nominal_label:   rate_label = 18'h0_BB80;
			pulled_up_double_rate_nominal_label:
			                                rate_label = 18'h1_7700;
			default:                        rate_label = rate_hz(r);
		endcase
	endfunction

	typedef struct packed {
		logic [15:0] lfsr;
		logic [23:0] word;
		logic        valid;
	} itr_lane_state_type;
endpackage
`default_nettype wire

/* File: inc/itr_lane_if.sv */
/*
 * carrier between the router top and one word length lane.
 * assumes both ends share clk_i; no timing of its own.
 */
`default_nettype none
interface itr_lane_if;
	logic        smp_valid; // mixed sample strobe
	logic [23:0] mix;       // saturated track mix
	logic        word16;    // 16-bit storage
	logic        dither;    // dither enable
	logic [23:0] word;      // reduced word
	logic        word_valid;
	modport feed (output smp_valid, mix, word16, dither,
	              input  word, word_valid);
	modport lane (input  smp_valid, mix, word16, dither,
	              output word, word_valid);
endinterface
`default_nettype wire

/* File: hw/itr_lane.sv */
/*
 * word length lane: passes 24-bit words or reduces them to 16 bits
 * by dither or truncation. assumes one strobe per sample period.
 */
`default_nettype none
module itr_lane
	import itr_pkg::*;
#(
	parameter logic [15:0] SEED = LFSR_SEED // per-lane dither seed
) (
	input wire logic clk_i,      // system clock
	input wire logic rst_i,      // sync reset, high
	itr_lane_if.lane lp          // mix in, word out
);
	itr_lane_state_type s_reg;
	itr_lane_state_type s_next;
	logic [24:0] dsum;
	logic [23:0] dsat;
	logic [15:0] w16;

	// next word and dither sequence
	always_comb begin
		s_next = s_reg;
		dsum = {lp.mix[23], lp.mix} +
			{{(25 - DITH_W){s_reg.lfsr[DITH_W-1]}}, s_reg.lfsr[DITH_W-1:0]};
		if (dsum[24] != dsum[23]) begin
			dsat = dsum[24] ? NEG_FS : POS_FS; // no wrap from dither
		end else begin
			dsat = dsum[23:0];
		end
		if (lp.dither) begin
			w16 = dsat[SMP_W-1:DROP_BITS];
		end else begin
			w16 = lp.mix[SMP_W-1:DROP_BITS]; // low byte dropped
		end
		s_next.valid = lp.smp_valid;
		if (lp.smp_valid) begin
			s_next.lfsr = s_reg.lfsr[0] ?
				((s_reg.lfsr >> 1) ^ LFSR_TAPS) : (s_reg.lfsr >> 1);
			s_next.word = lp.word16 ?
				{{(SMP_W - OUT16_W){w16[15]}}, w16} : lp.mix;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '{lfsr: SEED, word: 24'h00_0000, valid: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign lp.word       = s_reg.word;
	assign lp.word_valid = s_reg.valid;
endmodule
`default_nettype wire

/* File: hw/itr_top.sv */
/*
 * input to track router: 2x2 routing matrix with presets and editing,
 * mixing, muting, indicators, rate labelling and word length lanes.
 * assumes a classic wishbone master on clk_i, converter words in sync
 * with clk_i and one smp_valid_i pulse per word clock period.
 */
// Our own choices: the Wishbone register port and the register offsets.
// Functional notes
// - each input may feed either or both tracks, one bit per pair.
// - inputs sharing a track are added into a mono mix.
// - a 2x2 indicator lights steadily for each assigned pair.
// - a request steps cyclically through four presets; last three editable.
// - while editing, the selected pair's indicator flashes.
// - assign sets the selected pair's bit, clear removes it.
// - commit ends editing and always returns to the main state.
// - a mute per input silences it, keeping its routing bits.
// - an input's peak indicator is lit steadily while muted.
// - single-track files: a muted track gets no writes.
// - multi-track files: both tracks written, muted one as silence.
// - all tracks use one selected rate from 32 kHz to 192 kHz.
// - on external clock, label with the nearest generated rate.
// - three pulled rates are labelled 48 kHz or 96 kHz nominally.
// - storage word length is 16 or 24 bits.
// - 16-bit with dither adds random dither before reducing.
// - 16-bit without dither drops the lowest eight bits.
// - no rate or word length change on material being recorded.
// - peak indicator lights at or above -3 dBFS, before routing.
`default_nettype none
module itr_top
	import itr_pkg::*;
#(
	parameter int unsigned BLINK_CYCLES = BLINK_CYC // flash half period
) (
	input  wire logic        clk_i,         // system clock
	input  wire logic        rst_i,         // sync reset, high
	input  wire logic        cyc_i,         // wishbone cycle
	input  wire logic        stb_i,         // wishbone strobe
	input  wire logic        we_i,          // wishbone write
	input  wire logic [7:0]  adr_i,         // byte address
	input  wire logic [3:0]  sel_i,         // byte lanes
	input  wire logic [31:0] dat_i,         // write data
	output logic             ack_o,         // wishbone ack
	output logic      [31:0] dat_o,         // read data
	input  wire logic [23:0] in_a_i,        // input 1 word
	input  wire logic [23:0] in_b_i,        // input 2 word
	input  wire logic        smp_valid_i,   // word clock strobe
	input  wire logic        rec_i,         // recording active
	input  wire logic [17:0] ext_rate_hz_i, // measured external rate
	output logic      [3:0]  route_led_o,   // matrix indicators
	output logic      [1:0]  peak_led_o,    // input peak indicators
	output logic             edit_active_o, // editing in progress
	output logic      [23:0] trk_a_o,       // track a word
	output logic      [23:0] trk_b_o,       // track b word
	output logic             trk_valid_o,   // words valid
	output logic      [1:0]  trk_we_o,      // per-track write
	output logic             word16_o,      // 16-bit storage
	output logic      [17:0] rate_hz_o,     // generated rate
	output logic      [17:0] rate_label_o   // file header rate
);
	typedef struct packed {
		itr_ui_type           ui;
		logic [1:0]           preset;
		logic [3:0][3:0]      routes;
		logic [1:0]           cursor;
		logic [1:0]           mute;
		logic                 word16;
		logic                 dither;
		logic                 multi;
		logic                 ext_sel;
		itr_rate_type         rate;
		logic [17:0]          label;
		logic [17:0]          gen_hz;
		logic [1:0]           level;
		logic [1:0]           peak;
		logic [BLINK_W-1:0]   blink_cnt;
		logic                 blink;
		logic [3:0]           led;
		logic [1:0]           trk_we;
		logic                 ack;
		logic [31:0]          dat;
	} itr_top_state_type;

	itr_top_state_type s_reg;
	itr_top_state_type s_next;

	// one carrier for each track lane
	itr_lane_if lane_a ();
	itr_lane_if lane_b ();

	// parameter sanity
	if (BLINK_CYCLES < 2 || BLINK_CYCLES >= (2 ** BLINK_W)) begin : g_chk
		$error("BLINK_CYCLES out of range");
	end

	// mix, peak and lane logic are written for 24-bit words cut to 16
	if (SMP_W != 24 || OUT16_W + DROP_BITS != SMP_W) begin : g_chk_w
		$error("sample width constants do not fit the logic");
	end

	// last count of one flash half period
	localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_CYCLES - 1);

	// combinational helpers
	logic        wb_hit;
	logic        wb_wr;
	logic [3:0]  active;
	logic [23:0] in_w [2];
	logic [23:0] mix_w [2];
	logic [24:0] acc;
	logic [23:0] mag;
	logic [1:0]  live;
	logic [1:0]  editable_route_preset;
	logic        route_clear_request;

	// nearest generated rate, pulled ones included, to a measured one
	function automatic logic [17:0] nearest(input logic [17:0] hz);
		logic [17:0] b;
		logic [17:0] bd;
		logic [17:0] c;
		logic [17:0] cd;
		itr_rate_type r;
		b = rate_hz(rate_32k);
		bd = (hz > b) ? (hz - b) : (b - hz);
		// pulled codes only relabel, so they never win; a tie keeps
		// the lower rate because the compare is strict
		for (int k = 1; k < RATE_CNT; k++) begin
			r = itr_rate_type'(4'(k));
			c = rate_hz(r);
			cd = (hz > c) ? (hz - c) : (c - hz);
			if (r != pulled_down_rate_nominal_label &&
			    r != pulled_up_rate_nominal_label &&
			    r != pulled_up_double_rate_nominal_label && cd < bd) begin
				b = c;
				bd = cd;
			end
		end
		return b;
	endfunction

	// input array and bus decode; ack blocks a second take
	assign in_w[0] = in_a_i;
	assign in_w[1] = in_b_i;
	assign wb_hit  = cyc_i && stb_i && !s_reg.ack;
	assign wb_wr   = wb_hit && we_i;
	assign active  = s_reg.routes[s_reg.preset];
	assign editable_route_preset = s_reg.preset;
	assign route_clear_request =
		wb_wr && adr_i == ADR_CMD && sel_i[0] && dat_i[CMD_CLEAR];

	// track mixes from the active matrix; the 25-bit sum cannot wrap,
	// so overflow shows as a sign mismatch and is clamped instead
	always_comb begin
		for (int t = 0; t < 2; t++) begin
			acc = 25'h000_0000;
			for (int i = 0; i < 2; i++) begin
				if (active[i*2+t] && !s_reg.mute[i]) begin
					acc = acc + {in_w[i][23], in_w[i]};
				end
			end
			if (acc[24] != acc[23]) begin
				mix_w[t] = acc[24] ? NEG_FS : POS_FS;
			end else begin
				mix_w[t] = acc[23:0];
			end
			live[t] = (active[t] && !s_reg.mute[0]) ||
				(active[2+t] && !s_reg.mute[1]);
		end
	end

	// registers, commands, indicators and sample bookkeeping
	always_comb begin
		s_next = s_reg;
		mag = 24'h00_0000;
		s_next.ack = wb_hit;
		// settings writes; mute stays free while recording, the rest
		// is frozen so a file never changes format midway
		if (wb_wr && adr_i == ADR_CTRL) begin
			if (sel_i[0]) begin
				s_next.mute = dat_i[CTL_MUTE_LSB +: 2];
				if (!rec_i) begin
					s_next.word16  = dat_i[CTL_W16_BIT];
					s_next.dither  = dat_i[CTL_DITH_BIT];
					s_next.multi   = dat_i[CTL_MULT_BIT];
					s_next.ext_sel = dat_i[CTL_EXT_BIT];
				end
			end
			if (sel_i[1] && !rec_i &&
			    dat_i[CTL_RATE_LSB +: 4] < 4'(RATE_CNT)) begin
				s_next.rate = itr_rate_type'(dat_i[CTL_RATE_LSB +: 4]);
			end
		end
		// ui commands
		if (wb_wr && adr_i == ADR_CMD && sel_i[0]) begin
			case (s_reg.ui)
				st_main: begin
					if (dat_i[CMD_PRESET]) begin
						s_next.preset = s_reg.preset + 2'd1;
					end
					if (dat_i[CMD_EDIT] && s_reg.preset != 2'd0) begin
						s_next.ui = st_edit; // fixed preset is not editable
						s_next.cursor = 2'd0;
					end
				end
				st_edit: begin
					// cursor, then assign, then clear: clear wins
					if (dat_i[CMD_CURSOR]) begin
						s_next.cursor = s_reg.cursor + 2'd1;
					end
					if (dat_i[CMD_ASSIGN]) begin
						s_next.routes[editable_route_preset][s_next.cursor] =
							1'b1;
					end
					if (route_clear_request) begin
						s_next.routes[editable_route_preset][s_next.cursor] =
							1'b0;
					end
					if (dat_i[CMD_COMMIT]) begin
						s_next.ui = st_main;
					end
				end
				default: begin
					s_next.ui = st_main;
				end
			endcase
		end
		// flash timer for the selected pair
		// the flash phase restarts lit each time editing begins
		if (s_reg.ui == st_edit) begin
			if (s_reg.blink_cnt == BLINK_LAST) begin
				s_next.blink_cnt = '0;
				s_next.blink = !s_reg.blink;
			end else begin
				s_next.blink_cnt = s_reg.blink_cnt + 1'b1;
			end
		end else begin
			s_next.blink_cnt = '0;
			s_next.blink = 1'b1;
		end
		for (int b = 0; b < 4; b++) begin
			if (s_reg.ui == st_edit && s_reg.cursor == 2'(b)) begin
				s_next.led[b] = s_reg.blink;
			end else begin
				s_next.led[b] = active[b];
			end
		end
		// peak detect on raw inputs, ahead of routing and mute;
		// the most negative word negates to itself and still counts
		for (int i = 0; i < 2; i++) begin
			if (smp_valid_i) begin
				mag = in_w[i][23] ? (24'h00_0000 - in_w[i]) : in_w[i];
				s_next.level[i] = mag >= PEAK_LEVEL;
			end
			s_next.peak[i] = s_next.level[i] || s_next.mute[i];
		end
		// per-track writes line up with the lane output
		// single-track files skip a track with no unmuted input
		if (smp_valid_i) begin
			s_next.trk_we = s_reg.multi ? 2'b11 : live;
		end else begin
			s_next.trk_we = 2'b00;
		end
		// generated rate, held in a flop like the other data outputs
		s_next.gen_hz = rate_hz(s_reg.rate);
		// file header rate; pulled codes carry their nominal label
		if (s_reg.ext_sel) begin
			s_next.label = nearest(ext_rate_hz_i);
		end else begin
			s_next.label = rate_label(s_reg.rate);
		end
		// read data
		if (wb_hit && !we_i) begin
			case (adr_i)
				ADR_CTRL:  s_next.dat = {20'h0_0000, s_reg.rate, 2'b00,
					s_reg.ext_sel, s_reg.multi, s_reg.dither, s_reg.word16,
					s_reg.mute};
				ADR_ROUTE: s_next.dat = {24'h00_0000, s_reg.preset,
					s_reg.cursor, active};
				ADR_STAT:  s_next.dat = {28'h000_0000, rec_i,
					s_reg.ui == st_edit, s_reg.peak};
				ADR_LABEL: s_next.dat = {14'h0000, s_reg.label};
				default:   s_next.dat = 32'h0000_0000;
			endcase
		end
	end

	// state register; preset 0 is the fixed route after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '{
				ui: st_main, preset: 2'd0,
				routes: {ROUTE_RST3, ROUTE_RST2, ROUTE_RST1, ROUTE_RST0},
				cursor: 2'd0, mute: 2'b00, word16: 1'b0, dither: DITH_RST,
				multi: 1'b0, ext_sel: 1'b0, rate: RATE_RST,
				label: 18'h0_BB80, gen_hz: 18'h0_BB80, level: 2'b00,
				peak: 2'b00, blink_cnt: '0, blink: 1'b1, led: ROUTE_RST0,
				trk_we: 2'b00, ack: 1'b0, dat: 32'h0000_0000};
		end else begin
			s_reg <= s_next;
		end
	end

	// lane feeds; recorded words only ever pass through once
	assign lane_a.smp_valid = smp_valid_i;
	assign lane_a.mix       = mix_w[0];
	assign lane_a.word16    = s_reg.word16;
	assign lane_a.dither    = s_reg.dither;
	assign lane_b.smp_valid = smp_valid_i;
	assign lane_b.mix       = mix_w[1];
	assign lane_b.word16    = s_reg.word16;
	assign lane_b.dither    = s_reg.dither;

	// two lanes; different seeds keep the track dithers uncorrelated
	itr_lane #(
		.SEED (LFSR_SEED)
	) u_lane_a (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.lp    (lane_a.lane)
	);

	itr_lane #(
		.SEED (~LFSR_SEED)
	) u_lane_b (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.lp    (lane_b.lane)
	);

	// outputs
	assign ack_o         = s_reg.ack;
	assign dat_o         = s_reg.dat;
	assign route_led_o   = s_reg.led;
	assign peak_led_o    = s_reg.peak;
	assign edit_active_o = s_reg.ui == st_edit;
	assign trk_a_o       = lane_a.word;
	assign trk_b_o       = lane_b.word;
	assign trk_valid_o   = lane_a.word_valid && lane_b.word_valid;
	assign trk_we_o      = s_reg.trk_we;
	assign word16_o      = s_reg.word16;
	assign rate_hz_o     = s_reg.gen_hz;
	assign rate_label_o  = s_reg.label;
endmodule
`default_nettype wire

/* File: bench/itr_chk.sv */
/* port checker of the input track router top.
 * bound into every itr_top; sees its ports only. */
`default_nettype none
module itr_chk
	import itr_pkg::*;
#(
	parameter int unsigned BLINK_CYCLES = 4 // flash half period
) (
	input wire logic        clk_i,         // clock
	input wire logic        rst_i,         // sync reset
	input wire logic        cyc_i,         // bus cycle
	input wire logic        stb_i,         // bus strobe
	input wire logic        we_i,          // bus write
	input wire logic [7:0]  adr_i,         // address
	input wire logic [3:0]  sel_i,         // byte lanes
	input wire logic [31:0] dat_i,         // write data
	input wire logic        ack_o,         // bus ack
	input wire logic        smp_valid_i,   // sample strobe
	input wire logic        rec_i,         // recording
	input wire logic        trk_valid_o,   // words valid
	input wire logic [1:0]  trk_we_o,      // track writes
	input wire logic [23:0] trk_a_o,       // track a word
	input wire logic        word16_o,      // 16-bit mode
	input wire logic [17:0] rate_hz_o,     // rate
	input wire logic [1:0]  peak_led_o,    // peak leds
	input wire logic        edit_active_o  // editing
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// bus take and one-cycle answer
	sequence s_take; cyc_i && stb_i && !ack_o; endsequence
	sequence s_ans; ack_o ##1 !ack_o; endsequence
	sequence s_smp; smp_valid_i ##1 trk_valid_o; endsequence
	AST_ACK_ONE: assert property (s_take |=> s_ans)
		else $error("bus answer not a single ack");
	AST_SMP_ANS: assert property (smp_valid_i |-> s_smp)
		else $error("sample gave no track words");
	AST_NO_SPUR: assert property (!smp_valid_i |=> !trk_valid_o)
		else $error("track words without a sample");
	AST_WE_VALID: assert property (trk_valid_o || trk_we_o == 2'b00)
		else $error("track write outside a sample");
	AST_W16_SEXT: assert property (word16_o && trk_valid_o |->
		trk_a_o[23:16] == {8{trk_a_o[15]}})
		else $error("short word not sign extended");
	AST_RATE_SPAN: assert property (rate_hz_o >= 18'h0_7D00
		&& rate_hz_o <= 18'h2_EE00)
		else $error("rate outside span");
	AST_REC_LOCK: assert property (rec_i && $past(rec_i)
		|-> $stable(word16_o))
		else $error("word length moved while recording");
	AST_MUTE_PEAK: assert property (cyc_i && stb_i && we_i && !ack_o
		&& adr_i == ADR_CTRL && sel_i[0] && dat_i[0]
		|-> ##[1:3] peak_led_o[0])
		else $error("muted input peak not lit");
	AST_COMMIT: assert property (edit_active_o && cyc_i && stb_i && we_i
		&& !ack_o && adr_i == ADR_CMD && sel_i[0] && dat_i[CMD_COMMIT]
		|-> ##[1:2] !edit_active_o)
		else $error("commit left editing on");
endmodule
bind itr_top itr_chk #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (.*);
`default_nettype wire

/* File: bench/itr_src.sv */
/* converter and file writer model for the router.
 * send() waits for the next rising edge of clk_i, so the bench may call it at any time. */
`default_nettype none
module itr_src (
	input  wire logic        clk_i,       // system clock
	input  wire logic        trk_valid_i, // words valid
	input  wire logic [1:0]  trk_we_i,    // track writes
	output logic      [23:0] a_o,         // input 1 word
	output logic      [23:0] b_o,         // input 2 word
	output logic             smp_o        // sample strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned wr_a = 0;
	int unsigned wr_b = 0;
	initial begin
		a_o = 24'h00_0000;
		b_o = 24'h00_0000;
		smp_o = 1'b0;
	end
	// one word pair; words scrambled once taken
	task automatic send(input logic [23:0] a, input logic [23:0] b);
		@(posedge clk_i);
		a_o <= a;
		b_o <= b;
		smp_o <= 1'b1;
		@(posedge clk_i);
		a_o <= ~a;
		b_o <= ~b;
		smp_o <= 1'b0;
	endtask
	// writer counts stored words per track
	always @(posedge clk_i) begin
		if (trk_valid_i) begin
			wr_a <= wr_a + trk_we_i[0];
			wr_b <= wr_b + trk_we_i[1];
		end
	end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
/* self-checking bench of the input track router.
 * drives the bus and the source model; expects itr_chk bound. */
`default_nettype none
module tb
	import itr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned BLK = 4;
	logic        clk_i = 1'b0, rst_i = 1'b1, rec_i = 1'b0;
	logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [17:0] ext_rate_hz_i = 18'h0_BB80;
	logic        ack_o, edit_active_o, trk_valid_o, word16_o, smp_valid_i;
	logic [31:0] dat_o, rd;
	logic [23:0] in_a_i, in_b_i, trk_a_o, trk_b_o;
	logic [3:0]  route_led_o;
	logic [1:0]  peak_led_o, trk_we_o;
	logic [17:0] rate_hz_o, rate_label_o;
	int          n_errors = 0, samples_checked = 0;

	itr_top #(.BLINK_CYCLES(BLK)) i_dut (.*);
	itr_src u_src (.clk_i(clk_i), .trk_valid_i(trk_valid_o),
		.trk_we_i(trk_we_o), .a_o(in_a_i), .b_o(in_b_i), .smp_o(smp_valid_i));

	// 250 MHz clock
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e,
		input string w);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %0t %s: got %h want %h", $time, w, s, e);
		end
	endtask
	// classic single bus cycle; ack and read data taken at a rising edge
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input string w);
		wb(1'b0, a, 32'h0000_0000);
		chk(rd, e, w);
		@(negedge clk_i);
	endtask
	task automatic smp(input logic [23:0] a, input logic [23:0] b);
		u_src.send(a, b);
		@(negedge clk_i);
	endtask
	task automatic t_reset();
		rdc(ADR_CTRL, 32'h0000_0408, "ctrl");
		rdc(ADR_ROUTE, 32'h0000_0009, "route");
		rdc(ADR_LABEL, 32'h0000_BB80, "label");
		rdc(8'h14, 32'h0000_0000, "unmapped");
		chk(route_led_o, 4'h9, "led");
		$display("t_reset done");
	endtask
	task automatic t_mix();
		wb(1'b1, ADR_CTRL, 32'h0000_0404);
		repeat (3) wb(1'b1, ADR_CMD, 32'h0000_0001);
		rdc(ADR_ROUTE, 32'h0000_00CF, "preset 3");
		chk(route_led_o, 4'hF, "led all");
		smp(24'h70_0000, 24'h20_0000);
		chk(trk_valid_o, 1'b1, "valid");
		chk(trk_a_o, 24'h00_7FFF, "sat a");
		chk(trk_b_o, 24'h00_7FFF, "sum b");
		chk(peak_led_o, 2'b01, "peak");
		smp(24'h90_0000, 24'hA0_0000);
		chk(trk_a_o, 24'hFF_8000, "sat neg");
		chk(peak_led_o, 2'b11, "peak neg");
		wb(1'b1, ADR_CMD, 32'h0000_0001);
		rdc(ADR_ROUTE, 32'h0000_0009, "wrap");
		$display("t_mix done");
	endtask
	task automatic t_mute();
		int unsigned wa;
		int unsigned wbn;
		int lo;
		smp(24'h00_0000, 24'h00_0000);
		chk(peak_led_o, 2'b00, "quiet");
		wb(1'b1, ADR_CTRL, 32'h0000_0405);
		repeat (2) @(negedge clk_i);
		chk(peak_led_o, 2'b01, "mute peak");
		wa = u_src.wr_a;
		wbn = u_src.wr_b;
		smp(24'h10_0000, 24'h12_3456);
		chk(trk_we_o, 2'b10, "single we");
		chk(trk_b_o, 24'h00_1234, "trunc");
		rdc(ADR_ROUTE, 32'h0000_0009, "kept");
		chk(u_src.wr_a, wa, "no a write");
		chk(u_src.wr_b, wbn + 1, "b write");
		wb(1'b1, ADR_CTRL, 32'h0000_0415);
		smp(24'h10_0000, 24'h12_3456);
		chk(trk_we_o, 2'b11, "multi we");
		chk(trk_a_o, 24'h00_0000, "blank");
		wb(1'b1, ADR_CTRL, 32'h0000_0400);
		smp(24'h10_0000, 24'h12_3456);
		chk(trk_a_o, 24'h10_0000, "route a");
		chk(trk_b_o, 24'h12_3456, "full");
		wb(1'b1, ADR_CTRL, 32'h0000_040C);
		lo = 0;
		for (int i = 0; i < 8; i++) begin
			smp(24'h00_0000, 24'h12_3400);
			lo += (trk_b_o === 24'h00_1233);
		end
		chk(lo > 0 && lo < 8, 1'b1, "dither");
		$display("t_mute done");
	endtask
	task automatic t_edit();
		int tg;
		logic lst;
		wb(1'b1, ADR_CMD, 32'h0000_0001);
		wb(1'b1, ADR_CMD, 32'h0000_0002);
		wb(1'b1, ADR_CMD, 32'h0000_000C);
		rdc(ADR_ROUTE, 32'h0000_0057, "assign");
		rdc(ADR_STAT, 32'h0000_0004, "stat");
		tg = 0;
		lst = route_led_o[1];
		repeat (3 * BLK) begin
			@(negedge clk_i);
			tg += (route_led_o[1] !== lst);
			lst = route_led_o[1];
		end
		chk(tg >= 2, 1'b1, "flash");
		chk(route_led_o[2], 1'b1, "steady");
		wb(1'b1, ADR_CMD, 32'h0000_0010);
		rdc(ADR_ROUTE, 32'h0000_0055, "clear");
		wb(1'b1, ADR_CMD, 32'h0000_0020);
		@(negedge clk_i);
		chk(edit_active_o, 1'b0, "commit");
		chk(route_led_o, 4'h5, "led");
		$display("t_edit done");
	endtask
	task automatic t_rate();
		logic [3:0]  c[3] = '{4'h3, 4'h6, 4'hA};
		logic [17:0] l[3] = '{18'h0_BB80, 18'h0_BB80, 18'h1_7700};
		logic [17:0] h[3] = '{18'h0_BB50, 18'h0_BBB0, 18'h1_7760};
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, ADR_CTRL, {20'h0_0000, c[i], 8'h00});
			rdc(ADR_LABEL, {14'h0000, l[i]}, "label");
			chk(rate_label_o, l[i], "label pin");
			chk(rate_hz_o, h[i], "rate");
		end
		wb(1'b1, ADR_CTRL, 32'h0000_0D00);
		rdc(ADR_CTRL, 32'h0000_0A00, "bad code");
		@(posedge clk_i) ext_rate_hz_i <= 18'h0_BB76;
		wb(1'b1, ADR_CTRL, 32'h0000_0420);
		rdc(ADR_LABEL, 32'h0000_BB80, "ext low");
		@(posedge clk_i) ext_rate_hz_i <= 18'h0_BBA8;
		rdc(ADR_LABEL, 32'h0000_BBB0, "ext high");
		@(posedge clk_i) rec_i <= 1'b1;
		wb(1'b1, ADR_CTRL, 32'h0000_0404);
		rdc(ADR_CTRL, 32'h0000_0420, "locked");
		chk(word16_o, 1'b0, "lock w16");
		@(posedge clk_i) rec_i <= 1'b0;
		$display("t_rate done");
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// reset then the tests in turn
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_mix();
		t_mute();
		t_edit();
		t_rate();
		end_of_test();
	end
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
